// File: hdl/atdc_defines.svh
`ifndef ATDC_DEFINES_SVH
`define ATDC_DEFINES_SVH

`define ATDC_CTRL2_ADDR 8'h08
`define ATDC_STATUS_ADDR 8'h0c
`define ATDC_CTRL2_RESET 32'h0000_0000
`define ATDC_BIT_DMA 8
`define ATDC_BIT_ALIGN 11
`define ATDC_INJ_SEL_LO 12
`define ATDC_INJ_SEL_HI 14
`define ATDC_BIT_INJ_EN 15
`define ATDC_REG_SEL_LO 17
`define ATDC_REG_SEL_HI 19
`define ATDC_BIT_REG_EN 20
`define ATDC_BIT_INJ_SW 21
`define ATDC_BIT_REG_SW 22
`define ATDC_BIT_TVREF 23
`define ATDC_CTRL2_WMASK 32'h00fe_f900
`define ATDC_SW_CODE 3'h7
`define ATDC_RESP_OKAY 2'h0
`define ATDC_RESP_SLVERR 2'h2

`endif

// File: hdl/atdc_pkg.sv
package atdc_pkg;
  typedef struct packed {
    logic [31:0] ctrl;
    logic injPend;
    logic regPend;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic injStartOut;
    logic regStartOut;
  } atdc_state_s;

  typedef struct packed {
    logic [7:0] injEvents;
    logic [7:0] regEvents;
  } atdc_events_s;

  typedef struct packed {
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic [7:0] prev;
  } atdc_sync_s;
endpackage

// File: hdl/atdc_trig_sel.sv
`timescale 1ns/1ps
`include "atdc_defines.svh"
module atdc_trig_sel
  import atdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // trigger pins, one per code
  input wire logic [7:0] events,
  // control
  input wire logic [2:0] sel,
  input wire logic enable,
  // selected edge
  output logic fire
);
  atdc_sync_s sy_reg;
  atdc_sync_s sy_next;

  // two stages before anything looks at the pin
  always_comb begin
    sy_next.syncA = events;
    sy_next.syncB = sy_reg.syncA;
    sy_next.prev = sy_reg.syncB;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  // software code never fires from a pin
  assign fire = enable && (sel != `ATDC_SW_CODE)
                && sy_reg.syncB[sel] && !sy_reg.prev[sel];
endmodule

// File: hdl/atdc_control.sv
`timescale 1ns/1ps
`include "atdc_defines.svh"
// Behaviour
// - bit 8 enables dma requests; instance two never raises them
// - bit 11 selects result alignment: 0 right, 1 left
// - instances one and two: bits 14:12 pick injected trigger, codes 000 to 110 from pins
// - instance three: injected trigger codes map to its own timer list
// - bit 15 lets external events start injected group; 0 ignores them
// - instances one and two: bits 19:17 pick regular trigger source
// - instance three: regular trigger codes map to its own timer list
// - bit 20 lets external events start regular group
// - bit 21 with software code starts injected group; hardware clears on start
// - bit 22 with software code starts regular group; hardware clears on start
// - bit 23 enables temperature and reference channels, instance one only
module atdc_control
  import atdc_pkg::*;
#(
  parameter int INSTANCE = 1
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // trigger pins, bit index is the select code
  input wire atdc_events_s trigPins,
  // converter side
  input wire logic injStarted,
  input wire logic regStarted,
  input wire logic regEoc,
  output logic injStart,
  output logic regStart,
  output logic dmaMode,
  output logic dmaReq,
  output logic leftAlign,
  output logic tempVrefOn
);
  atdc_state_s st_reg;
  atdc_state_s st_next;
  logic injFire;
  logic regFire;
  logic [31:0] wmask;
  logic [31:0] strbMask;
  logic [31:0] merged;
  logic doWrite;
  logic injSwGo;
  logic regSwGo;

  // pins are wired per instance so bit index equals code
  atdc_trig_sel injSel (
    .mclk(mclk),
    .rstn(rstn),
    .events(trigPins.injEvents),
    .sel(st_reg.ctrl[`ATDC_INJ_SEL_HI:`ATDC_INJ_SEL_LO]),
    .enable(st_reg.ctrl[`ATDC_BIT_INJ_EN]),
    .fire(injFire)
  );

  atdc_trig_sel regSel (
    .mclk(mclk),
    .rstn(rstn),
    .events(trigPins.regEvents),
    .sel(st_reg.ctrl[`ATDC_REG_SEL_HI:`ATDC_REG_SEL_LO]),
    .enable(st_reg.ctrl[`ATDC_BIT_REG_EN]),
    .fire(regFire)
  );

  // temperature bit only exists in instance one
  assign wmask = (INSTANCE == 1) ? `ATDC_CTRL2_WMASK
               : (`ATDC_CTRL2_WMASK & ~(32'h1 << `ATDC_BIT_TVREF));

  always_comb begin
    strbMask = {{8{st_reg.wStrb[3]}}, {8{st_reg.wStrb[2]}},
                {8{st_reg.wStrb[1]}}, {8{st_reg.wStrb[0]}}};
  end

  assign awready = !st_reg.awHave && !st_reg.bValid;
  assign wready = !st_reg.wHave && !st_reg.bValid;
  assign arready = !st_reg.rValid;
  assign doWrite = st_reg.awHave && st_reg.wHave && !st_reg.bValid;

  always_comb begin
    st_next = st_reg;
    merged = st_reg.ctrl;
    st_next.injStartOut = 1'b0;
    st_next.regStartOut = 1'b0;
    if (awvalid && awready) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      st_next.wHave = 1'b1;
      st_next.wData = wdata;
      st_next.wStrb = wstrb;
    end
    if (doWrite) begin
      st_next.awHave = 1'b0;
      st_next.wHave = 1'b0;
      st_next.bValid = 1'b1;
      if (st_reg.awAddr == `ATDC_CTRL2_ADDR) begin
        st_next.bResp = `ATDC_RESP_OKAY;
        merged = strbMask & wmask;
        st_next.ctrl = (st_reg.ctrl & ~merged) | (st_reg.wData & merged);
      end else if (st_reg.awAddr == `ATDC_STATUS_ADDR) begin
        st_next.bResp = `ATDC_RESP_OKAY;
      end else begin
        st_next.bResp = `ATDC_RESP_SLVERR;
      end
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'b0;
    end
    // hardware clears once the converter reports the start
    if (injStarted) begin
      st_next.ctrl[`ATDC_BIT_INJ_SW] = 1'b0;
    end
    if (regStarted) begin
      st_next.ctrl[`ATDC_BIT_REG_SW] = 1'b0;
    end
    // software-start request raised from a fresh set of the bit
    injSwGo = st_next.ctrl[`ATDC_BIT_INJ_SW] && !st_reg.ctrl[`ATDC_BIT_INJ_SW]
              && st_reg.ctrl[`ATDC_INJ_SEL_HI:`ATDC_INJ_SEL_LO] == `ATDC_SW_CODE;
    regSwGo = st_next.ctrl[`ATDC_BIT_REG_SW] && !st_reg.ctrl[`ATDC_BIT_REG_SW]
              && st_reg.ctrl[`ATDC_REG_SEL_HI:`ATDC_REG_SEL_LO] == `ATDC_SW_CODE;
    if (injSwGo) begin
      st_next.injPend = 1'b1;
    end
    if (regSwGo) begin
      st_next.regPend = 1'b1;
    end
    // software withdrawing the bit cancels a request not yet taken
    if (!st_next.ctrl[`ATDC_BIT_INJ_SW]) begin
      st_next.injPend = 1'b0;
    end
    if (!st_next.ctrl[`ATDC_BIT_REG_SW]) begin
      st_next.regPend = 1'b0;
    end
    // one pulse per request; pending only waits for the converter's answer
    st_next.injStartOut = injSwGo || injFire;
    st_next.regStartOut = regSwGo || regFire;
    if (arvalid && arready) begin
      st_next.rValid = 1'b1;
      if (araddr == `ATDC_CTRL2_ADDR) begin
        st_next.rData = st_reg.ctrl;
        st_next.rResp = `ATDC_RESP_OKAY;
      end else if (araddr == `ATDC_STATUS_ADDR) begin
        st_next.rData = {30'h0, st_reg.regPend, st_reg.injPend};
        st_next.rResp = `ATDC_RESP_OKAY;
      end else begin
        st_next.rData = 32'h0000_0000;
        st_next.rResp = `ATDC_RESP_SLVERR;
      end
    end else if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.ctrl <= `ATDC_CTRL2_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bvalid = st_reg.bValid;
  assign bresp = st_reg.bResp;
  assign rvalid = st_reg.rValid;
  assign rdata = st_reg.rData;
  assign rresp = st_reg.rResp;
  assign injStart = st_reg.injStartOut;
  assign regStart = st_reg.regStartOut;
  // second instance has no dma path at all
  assign dmaMode = (INSTANCE != 2) && st_reg.ctrl[`ATDC_BIT_DMA];
  assign dmaReq = dmaMode && regEoc;
  assign leftAlign = st_reg.ctrl[`ATDC_BIT_ALIGN];
  assign tempVrefOn = (INSTANCE == 1) && st_reg.ctrl[`ATDC_BIT_TVREF];
endmodule

// File: testbench/atdc_conv_model.sv
`timescale 1ns/1ps
module atdc_conv_model (
  // clock
  input wire logic mclk,
  // start requests and answers
  input wire logic injStart,
  input wire logic regStart,
  output logic injStarted,
  output logic regStarted,
  output logic regEoc
);
  logic [3:0] iq = 4'h0;
  logic [3:0] rq = 4'h0;
  always @(posedge mclk) begin
    iq <= {iq[2:0], injStart};
    rq <= {rq[2:0], regStart};
  end
  // acknowledges each start two cycles later, so the pending bit clears
  assign injStarted = iq[1];
  assign regStarted = rq[1];
  assign regEoc = rq[3];
endmodule

// File: testbench/atdc_control_chk.sv
`timescale 1ns/1ps
module atdc_control_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // converter
  input wire logic regEoc,
  input wire logic injStart,
  input wire logic regStart,
  input wire logic dmaMode,
  input wire logic dmaReq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_bHold; bvalid && !bready |=> bvalid; endproperty
  property p_rHold; rvalid && !rready |=> rvalid; endproperty
  property p_awBlock; bvalid |-> !awready; endproperty
  property p_arBlock; rvalid |-> !arready; endproperty
  property p_dma; dmaReq == (dmaMode && regEoc); endproperty
  property p_injPulse; injStart |=> !injStart; endproperty
  property p_regPulse; regStart |=> !regStart; endproperty
  property p_rsvZero;
    rvalid |-> rdata[31:24] == 8'h00 && !rdata[16] && rdata[10:9] == 2'h0;
  endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");
  a_rHold: assert property (p_rHold) else $error("rvalid dropped");
  a_awBlock: assert property (p_awBlock) else $error("awready during response");
  a_arBlock: assert property (p_arBlock) else $error("arready during response");
  a_dma: assert property (p_dma) else $error("dma request wrong");
  a_injPulse: assert property (p_injPulse) else $error("inj start too long");
  a_regPulse: assert property (p_regPulse) else $error("reg start too long");
  a_rsvZero: assert property (p_rsvZero) else $error("reserved bit set");
  c_inj: cover property (injStart);
  c_reg: cover property (regStart);
  c_dma: cover property (dmaReq);
endmodule
bind atdc_control atdc_control_chk chk_u (.mclk, .rstn, .awready, .bvalid, .bready, .arready,
  .rvalid, .rready, .rdata, .regEoc, .injStart, .regStart, .dmaMode, .dmaReq);

// File: testbench/adc_trigger_dma_control_tb.sv
`timescale 1ns/1ps
module adc_trigger_dma_control_tb;
  import atdc_pkg::*;
  logic mclk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rdD, lf = 32'h40d4;
  logic [3:0] wstrb = 4'hf;
  logic dmaMode2, tvref2;
  logic [1:0] bresp, rresp, rdR;
  logic awready, wready, bvalid, arready, rvalid, injStarted, regStarted, regEoc;
  logic injStart, regStart, dmaMode, dmaReq, leftAlign, tempVrefOn;
  atdc_events_s trigPins = '0;
  int error_cnt = 0, n_compared = 0, ni = 0, nr = 0, nd = 0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    ni += injStart;
    nr += regStart;
    nd += dmaReq;
  end
  atdc_control #(.INSTANCE(1)) dut_u (.mclk, .rstn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .trigPins, .injStarted, .regStarted, .regEoc,
    .injStart, .regStart, .dmaMode, .dmaReq, .leftAlign, .tempVrefOn);
  // second instance follows the same bus traffic; only its gated outputs are watched
  atdc_control #(.INSTANCE(2)) dut2_u (.mclk, .rstn, .awaddr, .awvalid, .awready(), .wdata,
    .wstrb, .wvalid, .wready(), .bresp(), .bvalid(), .bready, .araddr, .arvalid, .arready(),
    .rdata(), .rresp(), .rvalid(), .rready, .trigPins, .injStarted, .regStarted, .regEoc,
    .injStart(), .regStart(), .dmaMode(dmaMode2), .dmaReq(), .leftAlign(),
    .tempVrefOn(tvref2));
  atdc_conv_model cm_u (.mclk, .injStart, .regStart, .injStarted, .regStarted, .regEoc);
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end while (!bvalid);
    bready <= 0;
    // idle edge so a following call never re-drives ready in this step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar;
    ar = 1;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (ar && arready) begin
        ar = 0;
        arvalid <= 0;
      end
    end while (!rvalid);
    rdD = rdata;
    rdR = rresp;
    rready <= 0;
    @(posedge mclk);
  endtask
  // pins held two cycles so the synchroniser cannot miss the edge
  task automatic trg(input int c, input logic en);
    wr(8'h08, {11'h0, en, c[2:0], 1'h0, en, c[2:0], 12'h0});
    ni = 0;
    nr = 0;
    nd = 0;
    trigPins <= {2{8'h01 << c}};
    repeat (2) @(posedge mclk);
    trigPins <= '0;
    repeat (8) @(posedge mclk);
    chk("inj start", 32'(en), ni);
    chk("reg start", 32'(en), nr);
    chk("dma off", 0, nd);
  endtask
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    rd(8'h08);
    chk("reset", 0, rdD);
    repeat (12) begin
      lf = nx(lf);
      wr(8'h08, lf & 32'hff9f_ffff);
      rd(8'h08);
      chk("ctrl", lf & 32'h009e_f900, rdD);
      chk("dma", 32'(lf[8]), 32'(dmaMode));
      chk("align", 32'(lf[11]), 32'(leftAlign));
      chk("tvref", 32'(lf[23]), 32'(tempVrefOn));
      chk("dma two", 0, 32'(dmaMode2));
      chk("tvref two", 0, 32'(tvref2));
    end
    rd(8'h40);
    chk("bad resp", 2, 32'(rdR));
    chk("bad data", 0, rdD);
    for (int c = 0; c < 7; c++) begin
      trg(c, 0);
      trg(c, 1);
    end
    wr(8'h08, 32'h000e_7100);
    ni = 0;
    nr = 0;
    nd = 0;
    wr(8'h08, 32'h006e_7100);
    repeat (8) @(posedge mclk);
    chk("sw inj", 1, ni);
    chk("sw reg", 1, nr);
    chk("dma on", 1, nd);
    rd(8'h08);
    chk("sw clear", 32'h000e_7100, rdD);
    wstrb <= 4'h2;
    wr(8'h08, 32'h0000_0000);
    wstrb <= 4'hf;
    rd(8'h08);
    chk("strobe", 32'h000e_0000, rdD);
    report_and_stop;
  end
endmodule
